// >>> design/fpg_defs.svh
// Operation
// - software erases one 1024-byte page per sequence
// - 8-bit external write above 0x00FF never programs
// - programming only clears bits; erase sets them
// - byte program: enable write, keys, one write
// - bank field steers the flash operation
// - software checks target reads 0xFF first
// - block write commits four bytes, byte time
// - bytes 00b..10b cached, committed on 11b
// - cached bytes never programmed without 11b write
// - keys before each of four ascending writes
// - code reads see flash; external reads never
// - write needs write enable; erase needs both
// - last flash byte is the security byte
// - inverse of security byte counts locked pages
// - security page locked when any bit zero
// - security byte at 0x1FFFF; 0x80 locks all
// - wrong key order disables flash writes and erases until reset
// - key lock re-arms after every operation
// - cpu stalls while write or erase runs
// - supply monitor off causes flash error reset
`ifndef FPG_DEFS_SVH
`define FPG_DEFS_SVH
`define FPG_SFR_STORE_CTRL 8'h8f
`define FPG_SFR_BANK 8'hf5
`define FPG_SFR_KEY 8'hb7
`define FPG_SFR_BLOCK_CTRL 8'hb5
`define FPG_CTRL_WE_BIT 0
`define FPG_CTRL_EE_BIT 1
`define FPG_BLK_EN_BIT 0
`define FPG_KEY_FIRST 8'ha5
`define FPG_KEY_SECOND 8'hf1
`define FPG_BYTE_ADDR_MAX 16'h00ff
`define FPG_ERASED 8'hff
`define FPG_LOCK_ADDR 17'h1ffff
`define FPG_PAGE_LSB 10
`define FPG_BANK_WIN_BIT 15
`define FPG_LAST_IN_BLOCK 2'h3
`define FPG_CLK_PERIOD_NS 20
`define FPG_PROG_TIME_NS 20000
`define FPG_ERASE_TIME_NS 20000000
`endif

// >>> design/fpg_pkg.sv
package fpg_pkg;
    typedef enum logic [3:0] {
        KEY_IDLE = 4'h1,
        KEY_HALF = 4'h2,
        KEY_ARMED = 4'h4,
        KEY_DEAD = 4'h8
    } fpg_key_e;
    typedef enum logic [5:0] {
        ST_LOAD = 6'h01,
        ST_LOADCAP = 6'h02,
        ST_IDLE = 6'h04,
        ST_RDREQ = 6'h08,
        ST_RDCAP = 6'h10,
        ST_BUSY = 6'h20
    } fpg_st_e;
    typedef enum logic [1:0] {
        OP_ERASE = 2'h0,
        OP_BYTE = 2'h1,
        OP_BLOCK = 2'h2
    } fpg_op_e;
    typedef enum logic [11:0] {
        H_IDLE = 12'h001,
        H_CHECK = 12'h002,
        H_CHKW = 12'h004,
        H_BLK = 12'h008,
        H_CTRL = 12'h010,
        H_BANK = 12'h020,
        H_KEY1 = 12'h040,
        H_KEY2 = 12'h080,
        H_DATA = 12'h100,
        H_WAIT = 12'h200,
        H_CLRP = 12'h400,
        H_CLRB = 12'h800
    } fpg_host_e;
endpackage

// >>> design/fpg_if.sv
`timescale 1ns/1ps
interface fpg_if;
    logic sfr_wr;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic xwr;
    logic x_wide;
    logic [15:0] x_addr;
    logic [7:0] x_wdata;
    logic code_rd;
    logic [16:0] code_addr;
    logic [7:0] code_rdata;
    logic code_valid;
    logic [16:0] pc;
    logic stall;
    logic flash_err;
    modport dev (input sfr_wr, sfr_addr, sfr_wdata, xwr, x_wide, x_addr, x_wdata, code_rd, code_addr, pc,
        output sfr_rdata, code_rdata, code_valid, stall, flash_err);
    modport cpu (output sfr_wr, sfr_addr, sfr_wdata, xwr, x_wide, x_addr, x_wdata, code_rd, code_addr, pc,
        input sfr_rdata, code_rdata, code_valid, stall, flash_err);
endinterface

// >>> design/fpg_device.sv
`timescale 1ns/1ps
`include "fpg_defs.svh"
module fpg_device
    import fpg_pkg::*;
#(
    parameter int PROG_CYCLES = (`FPG_PROG_TIME_NS + `FPG_CLK_PERIOD_NS - 1) / `FPG_CLK_PERIOD_NS,
    parameter int ERASE_CYCLES = (`FPG_ERASE_TIME_NS + `FPG_CLK_PERIOD_NS - 1) / `FPG_CLK_PERIOD_NS
)(
    input wire logic MCLK_I,
    input wire logic RESET_I,
    fpg_if.dev BUS,
    input wire logic VDD_MON_EN_I,
    input wire logic VDD_MON_RESET_EN_I,
    output logic [16:0] FLASH_ADDR_O,
    output logic FLASH_RD_O,
    input wire logic [7:0] FLASH_RDATA_I,
    output logic FLASH_PROG_O,
    output logic [31:0] FLASH_WDATA_O,
    output logic FLASH_ERASE_O,
    output logic FLASH_ERROR_RESET_O,
    output logic [7:0] LOCKED_PAGES_O
);
    localparam logic [6:0] LOCK_PAGE = 7'(`FPG_LOCK_ADDR >> `FPG_PAGE_LSB);

    fpg_st_e st_r, st_nxt;
    fpg_key_e key_r, key_nxt;
    logic we_r, we_nxt, ee_r, ee_nxt, blk_r, blk_nxt;
    logic [1:0] bank_r, bank_nxt;
    logic [7:0] lock_r, lock_nxt;
    logic [31:0] cache_r, cache_nxt, merged_r, merged_nxt, cnt_r, cnt_nxt;
    logic [2:0] cvld_r, cvld_nxt;
    logic [16:0] base_r, base_nxt, faddr_r, faddr_nxt;
    logic [1:0] idx_r, idx_nxt, crd_r, crd_nxt;
    logic frd_r, frd_nxt, prog_r, prog_nxt, erase_r, erase_nxt, err_r, err_nxt;
    logic [7:0] sfr_rdata_r, sfr_rdata_nxt, code_rdata_r, code_rdata_nxt;
    logic code_valid_r, code_valid_nxt;

    // page lock test: page below the inverse count, or the security page when any page is locked
    function automatic logic page_locked(input logic [6:0] page, input logic [7:0] lock);
        logic [7:0] n;
        n = ~lock;
        page_locked = ({1'b0, page} < n) || (page == LOCK_PAGE && lock != `FPG_ERASED);
    endfunction

    logic [16:0] flat;
    logic tgt_locked, exec_locked, range_ok;
    // bank window on the upper half of the 16-bit space
    assign flat = BUS.x_addr[`FPG_BANK_WIN_BIT] ? {bank_r, BUS.x_addr[14:0]} : {2'h0, BUS.x_addr[14:0]};
    assign tgt_locked = page_locked(flat[16:`FPG_PAGE_LSB], lock_r);
    assign exec_locked = page_locked(BUS.pc[16:`FPG_PAGE_LSB], lock_r);
    assign range_ok = BUS.x_wide || (BUS.x_addr <= `FPG_BYTE_ADDR_MAX);

    // the core is frozen for the whole operation, including the lock load after reset
    assign BUS.stall = (st_r != ST_IDLE);
    assign BUS.sfr_rdata = sfr_rdata_r;
    assign BUS.code_rdata = code_rdata_r;
    assign BUS.code_valid = code_valid_r;
    assign BUS.flash_err = err_r;
    assign FLASH_ADDR_O = faddr_r;
    assign FLASH_RD_O = frd_r;
    assign FLASH_PROG_O = prog_r;
    assign FLASH_WDATA_O = merged_r;
    assign FLASH_ERASE_O = erase_r;
    assign FLASH_ERROR_RESET_O = err_r;
    assign LOCKED_PAGES_O = ~lock_r;

    // next state of sequencer, key lock, control bits and cache
    always_comb begin
        st_nxt = st_r;
        key_nxt = key_r;
        we_nxt = we_r;
        ee_nxt = ee_r;
        blk_nxt = blk_r;
        bank_nxt = bank_r;
        lock_nxt = lock_r;
        cache_nxt = cache_r;
        cvld_nxt = cvld_r;
        merged_nxt = merged_r;
        cnt_nxt = cnt_r;
        base_nxt = base_r;
        faddr_nxt = faddr_r;
        idx_nxt = idx_r;
        frd_nxt = 1'b0;
        prog_nxt = 1'b0;
        erase_nxt = 1'b0;
        err_nxt = 1'b0;
        crd_nxt = {crd_r[0], 1'b0};
        code_valid_nxt = crd_r[1];
        code_rdata_nxt = crd_r[1] ? FLASH_RDATA_I : code_rdata_r;
        // register writes
        if (BUS.sfr_wr) begin
            unique case (BUS.sfr_addr)
                `FPG_SFR_STORE_CTRL: begin
                    we_nxt = BUS.sfr_wdata[`FPG_CTRL_WE_BIT];
                    ee_nxt = BUS.sfr_wdata[`FPG_CTRL_EE_BIT];
                end
                `FPG_SFR_BANK: bank_nxt = BUS.sfr_wdata[1:0];
                `FPG_SFR_BLOCK_CTRL: begin
                    blk_nxt = BUS.sfr_wdata[`FPG_BLK_EN_BIT];
                    if (!BUS.sfr_wdata[`FPG_BLK_EN_BIT]) begin
                        cvld_nxt = 3'h0;
                    end
                end
                `FPG_SFR_KEY: begin
                    // any out-of-order or wrong code kills flash writes and erases until reset; code reads still go through
                    unique case (key_r)
                        KEY_IDLE: key_nxt = (BUS.sfr_wdata == `FPG_KEY_FIRST) ? KEY_HALF : KEY_DEAD;
                        KEY_HALF: key_nxt = (BUS.sfr_wdata == `FPG_KEY_SECOND) ? KEY_ARMED : KEY_DEAD;
                        KEY_ARMED: key_nxt = KEY_DEAD;
                        KEY_DEAD: key_nxt = KEY_DEAD;
                    endcase
                end
                default: ;
            endcase
        end
        unique case (st_r)
            ST_LOAD: begin
                frd_nxt = 1'b1;
                faddr_nxt = `FPG_LOCK_ADDR;
                st_nxt = ST_LOADCAP;
            end
            ST_LOADCAP: if (!frd_r) begin
                lock_nxt = FLASH_RDATA_I;
                st_nxt = ST_IDLE;
            end
            ST_IDLE: begin
                // code reads go to flash; external reads never reach this block
                if (BUS.code_rd) begin
                    if (page_locked(BUS.code_addr[16:`FPG_PAGE_LSB], lock_r) && !exec_locked) begin
                        err_nxt = 1'b1;
                    end else begin
                        frd_nxt = 1'b1;
                        faddr_nxt = BUS.code_addr;
                        crd_nxt = {crd_r[0], 1'b1};
                    end
                end
                // without write enable the write targets data ram and is ignored here
                if (BUS.xwr && we_r && range_ok) begin
                    if (key_r != KEY_ARMED) begin
                        key_nxt = KEY_DEAD;
                    end else if (!VDD_MON_EN_I || !VDD_MON_RESET_EN_I) begin
                        err_nxt = 1'b1;
                        key_nxt = KEY_IDLE;
                    end else if ((tgt_locked && !exec_locked) ||
                                 (ee_r && flat[16:`FPG_PAGE_LSB] == LOCK_PAGE)) begin
                        err_nxt = 1'b1;
                        key_nxt = KEY_IDLE;
                    end else begin
                        key_nxt = KEY_IDLE;
                        if (ee_r) begin
                            erase_nxt = 1'b1;
                            faddr_nxt = flat;
                            cnt_nxt = 32'(ERASE_CYCLES);
                            st_nxt = ST_BUSY;
                        end else if (blk_r && flat[1:0] != `FPG_LAST_IN_BLOCK) begin
                            // held back; only the last byte of the group programs
                            cache_nxt[8 * flat[1:0] +: 8] = BUS.x_wdata;
                            cvld_nxt[flat[1:0]] = 1'b1;
                        end else begin
                            base_nxt = {flat[16:2], 2'h0};
                            merged_nxt = {4{`FPG_ERASED}};
                            if (blk_r) begin
                                for (int i = 0; i < 3; i++) begin
                                    if (cvld_r[i]) begin
                                        merged_nxt[8 * i +: 8] = cache_r[8 * i +: 8];
                                    end
                                end
                                cvld_nxt = 3'h0;
                            end
                            merged_nxt[8 * flat[1:0] +: 8] = BUS.x_wdata;
                            idx_nxt = 2'h0;
                            st_nxt = ST_RDREQ;
                        end
                    end
                end
            end
            ST_RDREQ: begin
                frd_nxt = 1'b1;
                faddr_nxt = {base_r[16:2], idx_r};
                st_nxt = ST_RDCAP;
            end
            ST_RDCAP: if (!frd_r) begin
                // old bits and new bits: a one can never be written back over a zero
                merged_nxt[8 * idx_r +: 8] = merged_r[8 * idx_r +: 8] & FLASH_RDATA_I;
                if (idx_r == `FPG_LAST_IN_BLOCK) begin
                    prog_nxt = 1'b1;
                    faddr_nxt = base_r;
                    cnt_nxt = 32'(PROG_CYCLES);
                    st_nxt = ST_BUSY;
                end else begin
                    idx_nxt = idx_r + 2'h1;
                    st_nxt = ST_RDREQ;
                end
            end
            ST_BUSY: begin
                cnt_nxt = cnt_r - 32'h1;
                if (cnt_r <= 32'h1) begin
                    st_nxt = ST_IDLE;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        // readback: control bits, bank, block enable, key state
        unique case (BUS.sfr_addr)
            `FPG_SFR_STORE_CTRL: sfr_rdata_nxt = {6'h0, ee_r, we_r};
            `FPG_SFR_BANK: sfr_rdata_nxt = {6'h0, bank_r};
            `FPG_SFR_BLOCK_CTRL: sfr_rdata_nxt = {7'h0, blk_r};
            `FPG_SFR_KEY: sfr_rdata_nxt = {4'h0, key_r};
            default: sfr_rdata_nxt = 8'h00;
        endcase
    end

    // registers
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            st_r <= ST_LOAD;
            key_r <= KEY_IDLE;
            we_r <= 1'b0;
            ee_r <= 1'b0;
            blk_r <= 1'b0;
            bank_r <= 2'h0;
            lock_r <= `FPG_ERASED;
            cache_r <= 32'h0;
            cvld_r <= 3'h0;
            merged_r <= 32'h0;
            cnt_r <= 32'h0;
            base_r <= 17'h0;
            faddr_r <= 17'h0;
            idx_r <= 2'h0;
            crd_r <= 2'h0;
            frd_r <= 1'b0;
            prog_r <= 1'b0;
            erase_r <= 1'b0;
            err_r <= 1'b0;
            sfr_rdata_r <= 8'h00;
            code_rdata_r <= 8'h00;
            code_valid_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            key_r <= key_nxt;
            we_r <= we_nxt;
            ee_r <= ee_nxt;
            blk_r <= blk_nxt;
            bank_r <= bank_nxt;
            lock_r <= lock_nxt;
            cache_r <= cache_nxt;
            cvld_r <= cvld_nxt;
            merged_r <= merged_nxt;
            cnt_r <= cnt_nxt;
            base_r <= base_nxt;
            faddr_r <= faddr_nxt;
            idx_r <= idx_nxt;
            crd_r <= crd_nxt;
            frd_r <= frd_nxt;
            prog_r <= prog_nxt;
            erase_r <= erase_nxt;
            err_r <= err_nxt;
            sfr_rdata_r <= sfr_rdata_nxt;
            code_rdata_r <= code_rdata_nxt;
            code_valid_r <= code_valid_nxt;
        end
    end
endmodule

// >>> design/fpg_host.sv
`timescale 1ns/1ps
`include "fpg_defs.svh"
module fpg_host
    import fpg_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RESET_I,
    fpg_if.cpu BUS,
    input wire logic OP_START_I,
    input wire logic [1:0] OP_KIND_I,
    input wire logic [16:0] OP_ADDR_I,
    input wire logic [31:0] OP_DATA_I,
    input wire logic [16:0] PC_I,
    output logic OP_BUSY_O,
    output logic OP_DONE_O,
    output logic OP_FAIL_O
);
    fpg_host_e st_r, st_nxt;
    fpg_op_e kind_r, kind_nxt;
    logic [16:0] addr_r, addr_nxt;
    logic [31:0] data_r, data_nxt;
    logic [1:0] bi_r, bi_nxt;
    logic done_r, done_nxt, fail_r, fail_nxt;
    logic sfr_wr_r, sfr_wr_nxt, xwr_r, xwr_nxt, crd_r, crd_nxt;
    logic [7:0] sfr_addr_r, sfr_addr_nxt, sfr_wdata_r, sfr_wdata_nxt;
    logic [16:0] tgt;
    logic last;

    assign tgt = (kind_r == OP_BLOCK) ? {addr_r[16:2], bi_r} : addr_r;
    assign last = (kind_r != OP_BLOCK) || (bi_r == `FPG_LAST_IN_BLOCK);
    assign BUS.sfr_wr = sfr_wr_r;
    assign BUS.sfr_addr = sfr_addr_r;
    assign BUS.sfr_wdata = sfr_wdata_r;
    assign BUS.xwr = xwr_r;
    // short 8-bit form only where it may reach flash
    assign BUS.x_wide = (tgt[16:8] != 9'h0);
    // banked targets go through the upper window
    assign BUS.x_addr = {tgt[16:15] != 2'h0, tgt[14:0]};
    assign BUS.x_wdata = data_r[8 * bi_r +: 8];
    assign BUS.code_rd = crd_r;
    assign BUS.code_addr = tgt;
    assign BUS.pc = PC_I;
    assign OP_BUSY_O = (st_r != H_IDLE);
    assign OP_DONE_O = done_r;
    assign OP_FAIL_O = fail_r;

    // firmware routine, one register or memory write per step
    always_comb begin
        st_nxt = st_r;
        kind_nxt = kind_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        bi_nxt = bi_r;
        fail_nxt = fail_r;
        done_nxt = 1'b0;
        sfr_wr_nxt = 1'b0;
        sfr_addr_nxt = sfr_addr_r;
        sfr_wdata_nxt = 8'h00;
        xwr_nxt = 1'b0;
        crd_nxt = 1'b0;
        unique case (st_r)
            H_IDLE: if (OP_START_I) begin
                kind_nxt = fpg_op_e'(OP_KIND_I);
                addr_nxt = (OP_KIND_I == OP_BLOCK) ? {OP_ADDR_I[16:2], 2'h0} : OP_ADDR_I;
                data_nxt = OP_DATA_I;
                bi_nxt = (OP_KIND_I == OP_BLOCK) ? 2'h0 : OP_ADDR_I[1:0];
                fail_nxt = 1'b0;
                st_nxt = (OP_KIND_I == OP_ERASE) ? H_BLK : H_CHECK;
            end
            H_CHECK: if (!BUS.stall) begin
                crd_nxt = 1'b1;
                st_nxt = H_CHKW;
            end
            H_CHKW: if (BUS.flash_err) begin
                // a locked target read while pc is in an unlocked page answers with an error only; waiting for data would hang
                fail_nxt = 1'b1;
                done_nxt = 1'b1;
                st_nxt = H_IDLE;
            end else if (BUS.code_valid) begin
                if (BUS.code_rdata != `FPG_ERASED) begin
                    fail_nxt = 1'b1;
                    done_nxt = 1'b1;
                    st_nxt = H_IDLE;
                end else if (last) begin
                    bi_nxt = (kind_r == OP_BLOCK) ? 2'h0 : bi_r;
                    st_nxt = H_BLK;
                end else begin
                    bi_nxt = bi_r + 2'h1;
                    st_nxt = H_CHECK;
                end
            end
            H_BLK: begin
                sfr_wr_nxt = 1'b1;
                sfr_addr_nxt = `FPG_SFR_BLOCK_CTRL;
                sfr_wdata_nxt[`FPG_BLK_EN_BIT] = (kind_r == OP_BLOCK);
                st_nxt = H_CTRL;
            end
            H_CTRL: begin
                sfr_wr_nxt = 1'b1;
                sfr_addr_nxt = `FPG_SFR_STORE_CTRL;
                sfr_wdata_nxt[`FPG_CTRL_WE_BIT] = 1'b1;
                sfr_wdata_nxt[`FPG_CTRL_EE_BIT] = (kind_r == OP_ERASE);
                st_nxt = H_BANK;
            end
            H_BANK: begin
                sfr_wr_nxt = 1'b1;
                sfr_addr_nxt = `FPG_SFR_BANK;
                sfr_wdata_nxt = {6'h0, tgt[16:15]};
                st_nxt = H_KEY1;
            end
            H_KEY1: begin
                sfr_wr_nxt = 1'b1;
                sfr_addr_nxt = `FPG_SFR_KEY;
                sfr_wdata_nxt = `FPG_KEY_FIRST;
                st_nxt = H_KEY2;
            end
            H_KEY2: begin
                sfr_wr_nxt = 1'b1;
                sfr_addr_nxt = `FPG_SFR_KEY;
                sfr_wdata_nxt = `FPG_KEY_SECOND;
                st_nxt = H_DATA;
            end
            H_DATA: begin
                xwr_nxt = 1'b1;
                st_nxt = H_WAIT;
            end
            // stall rises the cycle after the data write; wait it out
            H_WAIT: if (BUS.flash_err) begin
                fail_nxt = 1'b1;
                st_nxt = H_CLRP;
            end else if (!BUS.stall && !xwr_r) begin
                if (last) begin
                    st_nxt = H_CLRP;
                end else begin
                    bi_nxt = bi_r + 2'h1;
                    st_nxt = H_KEY1;
                end
            end
            H_CLRP: begin
                sfr_wr_nxt = 1'b1;
                sfr_addr_nxt = `FPG_SFR_STORE_CTRL;
                st_nxt = H_CLRB;
            end
            H_CLRB: begin
                sfr_wr_nxt = 1'b1;
                sfr_addr_nxt = `FPG_SFR_BLOCK_CTRL;
                done_nxt = 1'b1;
                st_nxt = H_IDLE;
            end
        endcase
    end

    // registers
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            st_r <= H_IDLE;
            kind_r <= OP_ERASE;
            addr_r <= 17'h0;
            data_r <= 32'h0;
            bi_r <= 2'h0;
            done_r <= 1'b0;
            fail_r <= 1'b0;
            sfr_wr_r <= 1'b0;
            sfr_addr_r <= 8'h00;
            sfr_wdata_r <= 8'h00;
            xwr_r <= 1'b0;
            crd_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            kind_r <= kind_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            bi_r <= bi_nxt;
            done_r <= done_nxt;
            fail_r <= fail_nxt;
            sfr_wr_r <= sfr_wr_nxt;
            sfr_addr_r <= sfr_addr_nxt;
            sfr_wdata_r <= sfr_wdata_nxt;
            xwr_r <= xwr_nxt;
            crd_r <= crd_nxt;
        end
    end
endmodule

// >>> verification/fpg_asserts.sv
`timescale 1ns/1ps
`include "fpg_defs.svh"
module fpg_asserts
    import fpg_pkg::*;
#(
    parameter int PROG_CYCLES = 8,
    parameter int ERASE_CYCLES = 16
)(
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic xwr,
    input wire logic x_wide,
    input wire logic [15:0] x_addr,
    input wire logic code_rd,
    input wire logic code_valid,
    input wire logic stall,
    input wire logic flash_err
);
    logic we_r, we_nxt, blk_r, blk_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    // shadow of the enable bits plus a stall length counter
    always_comb begin
        we_nxt = we_r;
        blk_nxt = blk_r;
        if (sfr_wr && sfr_addr == `FPG_SFR_STORE_CTRL) begin
            we_nxt = sfr_wdata[`FPG_CTRL_WE_BIT];
        end
        if (sfr_wr && sfr_addr == `FPG_SFR_BLOCK_CTRL) begin
            blk_nxt = sfr_wdata[`FPG_BLK_EN_BIT];
        end
        cnt_nxt = stall ? cnt_r + 32'h1 : 32'h0;
    end
    // registers only
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            we_r <= 1'b0;
            blk_r <= 1'b0;
            cnt_r <= 32'h0;
        end else begin
            we_r <= we_nxt;
            blk_r <= blk_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);
    // a read ends in data or in an error, never silence
    sequence read_err_s; ##1 flash_err; endsequence
    sequence read_ans_s; ##3 code_valid; endsequence
    a_code_read_answer: assert property ((code_rd && !stall) |-> read_err_s or read_ans_s)
        else $error("code read got no answer");
    a_valid_has_cause: assert property (code_valid |-> $past(code_rd, 3))
        else $error("code valid without read");
    a_narrow_ignored: assert property ((xwr && !x_wide && !stall && x_addr > `FPG_BYTE_ADDR_MAX)
        |=> !stall && !flash_err) else $error("narrow write above limit acted");
    // short stalls are the lock load after reset; long ones: four 3-cycle reads plus program, or erase
    a_stall_length: assert property (($fell(stall) && cnt_r > 32'h4)
        |-> (cnt_r == 32'(PROG_CYCLES + 12) || cnt_r == 32'(ERASE_CYCLES))) else $error("bad stall length");
    a_op_needs_we: assert property ($rose(stall) |-> ($past(xwr) && we_r) || $past(code_rd))
        else $error("flash operation without write enable");
    a_err_has_cause: assert property (flash_err |-> $past(xwr) || $past(code_rd))
        else $error("flash error without access");
    a_cache_no_stall: assert property ((xwr && x_wide && !stall && blk_r
        && x_addr[1:0] != `FPG_LAST_IN_BLOCK) |=> !stall) else $error("cached byte touched flash");
    a_commit_stalls: assert property ((xwr && x_wide && !stall && we_r
        && (!blk_r || x_addr[1:0] == `FPG_LAST_IN_BLOCK)) |=> stall || flash_err) else $error("write did not start");
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic MCLK_I, RESET_I, vdd_en, vdd_rst_en, start, frd, fprog, ferase, ferr, busy, done, fail;
    logic [1:0] kind;
    logic [16:0] op_addr, pc, faddr;
    logic [31:0] op_data, fwdata;
    logic [7:0] frdata, locked;
    logic [7:0] mem [0:131071];
    int fail_count, cmp_count;
    fpg_if bus();
    fpg_device #(.PROG_CYCLES(8), .ERASE_CYCLES(16)) fpg_device_inst(.MCLK_I(MCLK_I), .RESET_I(RESET_I),
        .BUS(bus), .VDD_MON_EN_I(vdd_en), .VDD_MON_RESET_EN_I(vdd_rst_en), .FLASH_ADDR_O(faddr),
        .FLASH_RD_O(frd), .FLASH_RDATA_I(frdata), .FLASH_PROG_O(fprog), .FLASH_WDATA_O(fwdata),
        .FLASH_ERASE_O(ferase), .FLASH_ERROR_RESET_O(ferr), .LOCKED_PAGES_O(locked));
    fpg_host fpg_host_inst(.MCLK_I(MCLK_I), .RESET_I(RESET_I), .BUS(bus), .OP_START_I(start),
        .OP_KIND_I(kind), .OP_ADDR_I(op_addr), .OP_DATA_I(op_data), .PC_I(pc), .OP_BUSY_O(busy),
        .OP_DONE_O(done), .OP_FAIL_O(fail));
    fpg_asserts #(.PROG_CYCLES(8), .ERASE_CYCLES(16)) fpg_asserts_inst(.MCLK_I(MCLK_I), .RESET_I(RESET_I),
        .sfr_wr(bus.sfr_wr), .sfr_addr(bus.sfr_addr), .sfr_wdata(bus.sfr_wdata), .xwr(bus.xwr),
        .x_wide(bus.x_wide), .x_addr(bus.x_addr), .code_rd(bus.code_rd), .code_valid(bus.code_valid),
        .stall(bus.stall), .flash_err(bus.flash_err));
    // clock
    initial begin
        MCLK_I = 1'b0;
        forever #10 MCLK_I = ~MCLK_I;
    end
    // flash array; stores what the device sends, so merging old bytes is the device's job
    always @(posedge MCLK_I) begin
        frdata <= frd ? mem[faddr] : ~frdata; // idle line toggles so stale data never passes
        if (fprog) begin
            for (int i = 0; i < 4; i++) mem[faddr + i] <= fwdata[8*i +: 8];
        end
        if (ferase) begin
            for (int i = 0; i < 1024; i++) mem[{faddr[16:10], 10'h000} + i] <= 8'hff;
        end
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // bounded wait for idle (want_done 0) or for the done pulse
    task wait_lvl(input bit want_done);
        int n;
        n = 0;
        while ((want_done ? done : ~busy) !== 1'b1) begin
            @(negedge MCLK_I);
            n++;
            if (n > 4000) begin
                fail_count++;
                final_report;
            end
        end
    endtask
    task run_op(input logic [1:0] k, input logic [16:0] a, input logic [31:0] d);
        wait_lvl(1'b0);
        kind = k;
        op_addr = a;
        op_data = d;
        start = 1'b1;
        @(negedge MCLK_I);
        start = 1'b0;
        wait_lvl(1'b1);
    endtask
    task do_reset;
        RESET_I = 1'b1;
        repeat (8) @(negedge MCLK_I);
        RESET_I = 1'b0;
    endtask
    // main sequence
    initial begin
        for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
        mem[17'h00011] = 8'h5a;
        {start, kind, op_addr, op_data} = '0;
        RESET_I = 1'b1;
        {vdd_en, vdd_rst_en, pc} = {2'h3, 17'h00800};
        @(negedge MCLK_I);
        do_reset;
        run_op(2'h1, 17'h00010, 32'h0000003c);
        check(fail, 32'h0);
        check(mem[17'h00010], 32'h3c);
        check(mem[17'h00011], 32'h5a);
        check(locked, 32'h0);
        run_op(2'h1, 17'h00010, 32'h0);
        check(fail, 32'h1);
        check(mem[17'h00010], 32'h3c);
        run_op(2'h2, 17'h10004, 32'h11223344);
        check(fail, 32'h0);
        check({mem[17'h10007], mem[17'h10006], mem[17'h10005], mem[17'h10004]}, 32'h11223344);
        run_op(2'h0, 17'h10006, 32'h0);
        check(fail, 32'h0);
        check({mem[17'h10007], mem[17'h10006], mem[17'h10005], mem[17'h10004]}, 32'hffffffff);
        check(mem[17'h00010], 32'h3c);
        vdd_en = 1'b0;
        run_op(2'h1, 17'h00020, 32'h0);
        check(fail, 32'h1);
        check(mem[17'h00020], 32'hff);
        vdd_en = 1'b1;
        // lock two pages and the security page, then act from an unlocked and from a locked page
        mem[17'h1ffff] = 8'hfd;
        do_reset;
        pc = 17'h01000;
        run_op(2'h1, 17'h00404, 32'h0);
        check(fail, 32'h1);
        check(locked, 32'h02);
        run_op(2'h1, 17'h00800, 32'h0);
        check(fail, 32'h0);
        check(mem[17'h00800], 32'h0);
        run_op(2'h1, 17'h1fff0, 32'h0);
        check(fail, 32'h1);
        pc = 17'h00100;
        run_op(2'h1, 17'h00404, 32'h0);
        check(fail, 32'h0);
        mem[17'h1ffff] = 8'h80;
        do_reset;
        // lock byte is loaded a few cycles after reset; host busy says nothing about it
        repeat (4) @(negedge MCLK_I);
        check(locked, 32'h7f);
        final_report;
    end
endmodule
